// ### hw/u_xcvr_test_pkg.sv
/*
  Constants of the transceiver test and debug block: register map,
  forced-transmit selections, trim codes and timing counts.
  Assumes a 100 MHz system clock and a 32-bit Avalon-MM slave.
*/
`default_nettype none
package u_xcvr_test_pkg;
  // ****************************************************
  // Bus and register map
  // ****************************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_FORCED_TX = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_TRIM = 4'hC;
  localparam logic [DATA_W-1:0] READ_UNMAPPED = 32'h0000_0000;
  // Forced transmit control: bit 7 enables, low nibble selects
  localparam int FTX_ENABLE_BIT = 7;
  localparam int FTX_SEL_W = 4;
  localparam logic [7:0] FTX_RESET = 8'h00;
  // Control register fields
  localparam int CTL_ROLE_BIT = 0;
  localparam int CTL_BUFOSC_OFF_BIT = 1;
  localparam int CTL_ACTIVE_BIT = 2;
  localparam logic [2:0] CTL_RESET = 3'h0;

  // ****************************************************
  // Forced transmit selections
  // ****************************************************
  typedef enum logic [3:0] {
    FTX_SL0 = 4'h0, FTX_SL1 = 4'h1, FTX_SL2 = 4'h2, FTX_SL3 = 4'h3,
    FTX_SN0 = 4'h4, FTX_SN1 = 4'h5, FTX_SN2 = 4'h6, FTX_SN3 = 4'h7,
    FTX_TN = 4'h8, FTX_TONE_10K = 4'h9, FTX_TONE_40K = 4'hA, FTX_ALT_QUAT = 4'hB
  } ftx_sel_t;
  localparam logic [3:0] FTX_LAST_SEL = 4'hB;

  // ****************************************************
  // Trim and clocks
  // ****************************************************
  localparam int TRIM_W = 8;
  localparam logic [TRIM_W-1:0] TRIM_MIN = 8'h00;
  localparam logic [TRIM_W-1:0] TRIM_CENTRE = 8'h80;
  localparam logic [TRIM_W-1:0] TRIM_MAX = 8'hFF;
  localparam int FLOAT_ENTRY_EDGES = 33;
  localparam int CLK_HZ = 100_000_000;
  localparam int TONE_10K_HZ = 10_000;
  localparam int TONE_40K_HZ = 40_000;
  // Half periods of the tones, rounded down
  localparam int TONE_10K_HALF = CLK_HZ / (2 * TONE_10K_HZ);
  localparam int TONE_40K_HALF = CLK_HZ / (2 * TONE_40K_HZ);
  // Reference with no edge for this long counts as static
  localparam int REF_STATIC_US = 200;
  localparam int REF_STATIC_CYCLES = REF_STATIC_US * (CLK_HZ / 1_000_000);
  // Divider ratio from system clock to the divided clock output
  localparam int DIV_OUT_RATIO = 24;
  localparam logic [1:0] QUAT_POS3 = 2'h3;
  localparam logic [1:0] QUAT_NEG3 = 2'h0;
  localparam logic [1:0] QUAT_POS1 = 2'h2;
  localparam logic [1:0] QUAT_NEG1 = 2'h1;
endpackage
`default_nettype wire

// ### hw/float_entry_detector.sv
/*
  Counts consecutive qualifying control-port clock rising edges and
  raises the float mode once the threshold is reached.
  Assumes port pins are synchronous to clk_sys.
*/
`default_nettype none
module float_entry_detector #(
  parameter int THRESHOLD = u_xcvr_test_pkg::FLOAT_ENTRY_EDGES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ctrl_port_enable_n,
  input wire logic ctrl_port_clock,
  input wire logic ctrl_port_serial_in,
  output logic all_outputs_float_mode
);
  localparam int CW = $clog2(THRESHOLD + 1);
  localparam logic [CW-1:0] LIMIT = CW'(THRESHOLD);
  localparam logic [CW-1:0] ONE = CW'(1);
  logic [CW-1:0] edge_count;
  logic clock_last;
  wire qualify = !ctrl_port_enable_n && ctrl_port_serial_in;
  wire rise = ctrl_port_clock && !clock_last;
  wire reached = (edge_count == LIMIT);
  wire [CW-1:0] next_edge_count = !qualify ? '0 : (rise && !reached) ? edge_count + ONE : edge_count;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      // Port clock idles high; avoids a false rise after reset
      clock_last <= 1'b1;
      edge_count <= '0;
      all_outputs_float_mode <= 1'b0;
    end
    else
    begin
      clock_last <= ctrl_port_clock;
      edge_count <= next_edge_count;
      // Exit at once on either condition failing
      all_outputs_float_mode <= qualify && (next_edge_count == LIMIT);
    end
  end
endmodule
`default_nettype wire

// ### hw/half_period_divider.sv
/*
  Square wave from the system clock by toggling every HALF cycles.
  Assumes HALF is at least one.
*/
`default_nettype none
module half_period_divider #(
  parameter int HALF = 2
) (
  input wire logic clk_sys,
  input wire logic reset,
  output logic wave
);
  localparam int CW = $clog2(HALF + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);
  localparam logic [CW-1:0] ONE = CW'(1);
  logic [CW-1:0] count;
  wire wrap = (count == LAST);

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      count <= '0;
      wave <= 1'b0;
    end
    else
    begin
      count <= wrap ? '0 : count + ONE;
      if (wrap)
        wave <= !wave;
    end
  end
endmodule
`default_nettype wire

// ### hw/u_xcvr_test_debug_control.sv
/*
  Test and debug control of the U-interface transceiver: output float
  detector, forced-transmit override and oscillator trim steering, with
  an Avalon-MM register slave.
  Assumes one clock clk_sys at 100 MHz and port pins synchronous to it.
*/
// The address map and the Avalon-MM slave port were chosen for this implementation.
// Overview of operation
// - Float mode starts after 33 consecutive port clock rises with enable low and serial in high.
// - In float mode the transmit symbol, buffered oscillator and divided clock outputs are released to high impedance.
// - Float mode ends as soon as enable rises or serial in falls.
// - Software may force the transmit framer through the forced transmit register, ignoring receive.
// - Selections are four line-start, four network, network tone, 10 kHz, 40 kHz and alternating quats.
// - As network termination and deactivated, the trim array takes the centre code.
// - As line termination with a static reference, the trim array goes to its maximum.
// - As line termination with a reference above the pull range, the trim array goes to its minimum.
// - A buffered copy of the oscillator is driven out and can be switched off.
// - A divided clock from the system clock is driven out as a second measurement point.
`default_nettype none
module u_xcvr_test_debug_control
  import u_xcvr_test_pkg::*;
#(
  parameter int REF_STATIC_LIMIT = u_xcvr_test_pkg::REF_STATIC_CYCLES,
  parameter int DIV_RATIO = u_xcvr_test_pkg::DIV_OUT_RATIO
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [u_xcvr_test_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [u_xcvr_test_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [u_xcvr_test_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ctrl_port_enable_n,
  input wire logic ctrl_port_clock,
  input wire logic ctrl_port_serial_in,
  input wire logic frequency_reference_in,
  input wire logic osc_in,
  input wire logic [1:0] framer_symbol,
  output logic [1:0] tx_symbol,
  output logic tx_symbol_oe,
  output logic tx_forced,
  output logic [u_xcvr_test_pkg::TRIM_W-1:0] trim_code,
  output logic buffered_osc_out,
  output logic buffered_osc_oe,
  output logic divided_clock_out,
  output logic divided_clock_oe,
  output logic all_outputs_float_mode
);
  import u_xcvr_test_pkg::*;

  // ****************************************************
  // Register slave
  // ****************************************************
  logic [7:0] forced_transmit_control;
  logic [2:0] control;
  logic answered;
  wire access = (avs_read || avs_write) && !answered;
  wire hit_ftx = (avs_address == OFS_FORCED_TX);
  wire hit_ctl = (avs_address == OFS_CONTROL);
  wire hit_sts = (avs_address == OFS_STATUS);
  wire hit_trim = (avs_address == OFS_TRIM);
  // Writes land at the answering edge, while the master still holds them
  wire wr_ftx = answered && avs_write && hit_ftx && avs_byteenable[0];
  wire wr_ctl = answered && avs_write && hit_ctl && avs_byteenable[0];
  wire float_mode;
  logic ref_static;
  logic ref_fast;
  wire [DATA_W-1:0] status_word = {{(DATA_W - 4){1'b0}}, ref_static, ref_fast, tx_forced, float_mode};
  wire [DATA_W-1:0] read_mux = hit_ftx ? {{(DATA_W - 8){1'b0}}, forced_transmit_control}
    : hit_ctl ? {{(DATA_W - 3){1'b0}}, control}
    : hit_sts ? status_word
    : hit_trim ? {{(DATA_W - TRIM_W){1'b0}}, trim_code}
    : READ_UNMAPPED;

  // One wait cycle: request sampled, answer with waitrequest low next edge
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      answered <= 1'b0;
      avs_readdata <= '0;
      forced_transmit_control <= FTX_RESET;
      control <= CTL_RESET;
    end
    else
    begin
      answered <= access;
      if (access && avs_read)
        avs_readdata <= read_mux;
      if (wr_ftx)
        forced_transmit_control <= avs_writedata[7:0];
      if (wr_ctl)
        control <= avs_writedata[2:0];
    end
  end
  assign avs_waitrequest = !answered;

  // ****************************************************
  // Float detector
  // ****************************************************
  float_entry_detector #(
    .THRESHOLD(FLOAT_ENTRY_EDGES)
  ) u_float (
    .clk_sys(clk_sys),
    .reset(reset),
    .ctrl_port_enable_n(ctrl_port_enable_n),
    .ctrl_port_clock(ctrl_port_clock),
    .ctrl_port_serial_in(ctrl_port_serial_in),
    .all_outputs_float_mode(float_mode)
  );
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      all_outputs_float_mode <= 1'b0;
    else
      all_outputs_float_mode <= float_mode;
  end

  // ****************************************************
  // Forced transmit pattern generator
  // ****************************************************
  logic tone_10k;
  logic tone_40k;
  logic quat_phase;
  half_period_divider #(
    .HALF(TONE_10K_HALF)
  ) u_tone10 (
    .clk_sys(clk_sys),
    .reset(reset),
    .wave(tone_10k)
  );
  half_period_divider #(
    .HALF(TONE_40K_HALF)
  ) u_tone40 (
    .clk_sys(clk_sys),
    .reset(reset),
    .wave(tone_40k)
  );
  wire force_on = forced_transmit_control[FTX_ENABLE_BIT];
  wire [FTX_SEL_W-1:0] force_sel = forced_transmit_control[FTX_SEL_W-1:0];
  wire sel_valid = (force_sel <= FTX_LAST_SEL);
  // Simplified symbol stand-ins: line-start and network signals of the same number share one pattern
  logic [1:0] forced_symbol;
  always_comb
  begin
    case (force_sel)
      FTX_SL0, FTX_SN0: forced_symbol = QUAT_POS3;
      FTX_SL1, FTX_SN1: forced_symbol = quat_phase ? QUAT_POS3 : QUAT_NEG3;
      FTX_SL2, FTX_SN2: forced_symbol = quat_phase ? QUAT_POS1 : QUAT_NEG1;
      FTX_SL3, FTX_SN3: forced_symbol = QUAT_NEG3;
      FTX_TN: forced_symbol = quat_phase ? QUAT_POS3 : QUAT_NEG3;
      FTX_TONE_10K: forced_symbol = tone_10k ? QUAT_POS3 : QUAT_NEG3;
      FTX_TONE_40K: forced_symbol = tone_40k ? QUAT_POS3 : QUAT_NEG3;
      FTX_ALT_QUAT: forced_symbol = quat_phase ? QUAT_POS1 : QUAT_NEG1;
      default: forced_symbol = QUAT_NEG1;
    endcase
  end
  // Receive side plays no part once forced
  wire do_force = force_on && sel_valid;
  wire [1:0] next_tx_symbol = do_force ? forced_symbol : framer_symbol;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      quat_phase <= 1'b0;
      tx_symbol <= QUAT_NEG1;
      tx_symbol_oe <= 1'b0;
      tx_forced <= 1'b0;
    end
    else
    begin
      quat_phase <= !quat_phase;
      tx_symbol <= next_tx_symbol;
      tx_symbol_oe <= !float_mode;
      tx_forced <= do_force;
    end
  end

  // ****************************************************
  // Reference classification and trim steering
  // ****************************************************
  localparam int RW = $clog2(REF_STATIC_LIMIT + 1);
  localparam logic [RW-1:0] REF_LIMIT = RW'(REF_STATIC_LIMIT);
  localparam logic [RW-1:0] REF_ONE = RW'(1);
  logic ref_last;
  logic [RW-1:0] ref_idle;
  wire ref_edge = frequency_reference_in && !ref_last;
  // Any edge inside the static window is beyond the pull range
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      ref_last <= 1'b0;
      // No edge seen yet counts as static until the first edge
      ref_idle <= REF_LIMIT;
      ref_static <= 1'b1;
      ref_fast <= 1'b0;
    end
    else
    begin
      ref_last <= frequency_reference_in;
      ref_idle <= ref_edge ? '0 : (ref_idle == REF_LIMIT) ? ref_idle : ref_idle + REF_ONE;
      ref_static <= (ref_idle == REF_LIMIT) && !ref_edge;
      ref_fast <= ref_edge || (ref_fast && ref_idle != REF_LIMIT);
    end
  end

  wire role_lt = control[CTL_ROLE_BIT];
  wire active = control[CTL_ACTIVE_BIT];
  wire [TRIM_W-1:0] next_trim = !role_lt ? (active ? trim_code : TRIM_CENTRE)
    : ref_static ? TRIM_MAX
    : ref_fast ? TRIM_MIN
    : TRIM_CENTRE;
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      trim_code <= TRIM_CENTRE;
    else
      trim_code <= next_trim;
  end

  // ****************************************************
  // Oscillator measurement outputs
  // ****************************************************
  localparam int DW = $clog2(DIV_RATIO);
  localparam logic [DW-1:0] DIV_HALF_LAST = DW'(DIV_RATIO / 2 - 1);
  localparam logic [DW-1:0] DIV_ONE = DW'(1);
  logic [DW-1:0] div_count;
  wire div_wrap = (div_count == DIV_HALF_LAST);
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      buffered_osc_out <= 1'b0;
      buffered_osc_oe <= 1'b0;
      div_count <= '0;
      divided_clock_out <= 1'b0;
      divided_clock_oe <= 1'b0;
    end
    else
    begin
      buffered_osc_out <= osc_in;
      buffered_osc_oe <= !control[CTL_BUFOSC_OFF_BIT] && !float_mode;
      div_count <= div_wrap ? '0 : div_count + DIV_ONE;
      if (div_wrap)
        divided_clock_out <= !divided_clock_out;
      divided_clock_oe <= !float_mode;
    end
  end
endmodule
`default_nettype wire

// ### testbench/u_xcvr_test_checker.sv
/* Port checker of the transceiver test and debug block.
   Bound to the block's top module; sees its ports only. */
`default_nettype none
module u_xcvr_test_checker (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [u_xcvr_test_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [u_xcvr_test_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic ctrl_port_enable_n,
  input wire logic ctrl_port_serial_in,
  input wire logic tx_symbol_oe,
  input wire logic buffered_osc_oe,
  input wire logic divided_clock_oe,
  input wire logic all_outputs_float_mode
);
  import u_xcvr_test_pkg::*;
  logic qual;
  logic mapped;
  assign qual = !ctrl_port_enable_n && ctrl_port_serial_in;
  assign mapped = avs_address inside {OFS_FORCED_TX, OFS_CONTROL, OFS_STATUS, OFS_TRIM};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ****
  // Assertions
  // ****
  sequence bus_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence bus_ans;
    !avs_waitrequest;
  endsequence
  chk_bus_answer: assert property (bus_req |=> bus_ans)
    else $error("bus answer not one cycle after request");
  chk_wait_once: assert property (bus_ans |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_unmapped_zero: assert property (avs_read && !mapped ##0 bus_ans |-> avs_readdata == READ_UNMAPPED)
    else $error("unmapped read not zero");
  chk_float_idle: assert property (ctrl_port_enable_n [*4] |-> !all_outputs_float_mode)
    else $error("float mode with enable high");
  chk_exit_enable: assert property ($rose(ctrl_port_enable_n) |-> ##[1:3] !all_outputs_float_mode)
    else $error("float mode kept after enable rose");
  chk_exit_serial: assert property ($fell(ctrl_port_serial_in) |-> ##[1:3] !all_outputs_float_mode)
    else $error("float mode kept after serial in fell");
  chk_float_quiet: assert property (all_outputs_float_mode [*2] |->
    !(tx_symbol_oe || buffered_osc_oe || divided_clock_oe))
    else $error("output driven in float mode");
  chk_float_hold: assert property (qual [*3] ##0 all_outputs_float_mode |=> all_outputs_float_mode)
    else $error("float mode lost while qualifying");
endmodule
bind u_xcvr_test_debug_control u_xcvr_test_checker u_xcvr_test_checker_i (.clk_sys, .reset, .avs_address,
  .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .ctrl_port_enable_n, .ctrl_port_serial_in,
  .tx_symbol_oe, .buffered_osc_oe, .divided_clock_oe, .all_outputs_float_mode);
`default_nettype wire

// ### testbench/ctrl_port_mcu_model.sv
/* Microcontroller model on the serial control port.
   Runs off the bench clock; lines idle high as pull-ups leave them. */
`default_nettype none
module ctrl_port_mcu_model (
  input wire logic clk_sys,
  output var logic ctrl_port_enable_n,
  output var logic ctrl_port_clock,
  output var logic ctrl_port_serial_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    ctrl_port_enable_n = 1'b1;
    ctrl_port_clock = 1'b1;
    ctrl_port_serial_in = 1'b1;
  end
  // Clock stands high between frames; each pulse is one sampled rise
  task automatic qualify(input int n);
    @(posedge clk_sys);
    ctrl_port_enable_n <= 1'b0;
    ctrl_port_serial_in <= 1'b1;
    repeat (n)
    begin
      @(posedge clk_sys);
      ctrl_port_clock <= 1'b0;
      @(posedge clk_sys);
      ctrl_port_clock <= 1'b1;
    end
  endtask
  task automatic leave(input bit by_enable);
    @(posedge clk_sys);
    if (by_enable)
      ctrl_port_enable_n <= 1'b1;
    ctrl_port_serial_in <= by_enable;
  endtask
endmodule
`default_nettype wire

// ### testbench/u_xcvr_test_debug_control_tb_top.sv
/* Self-checking bench of the transceiver test and debug block.
   Needs the package, the block, its checker and the port model. */
`default_nettype none
module u_xcvr_test_debug_control_tb_top import u_xcvr_test_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // Short static window keeps the trim runs brief
  localparam int REF_LIM = 50;
  localparam int DIV = 24;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] avs_address;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic ctrl_port_enable_n, ctrl_port_clock, ctrl_port_serial_in;
  logic frequency_reference_in = 1'b0;
  logic osc_in = 1'b0;
  logic osc_prev = 1'b0;
  logic [1:0] framer_symbol;
  logic [1:0] tx_symbol;
  logic [TRIM_W-1:0] trim_code;
  logic tx_symbol_oe, tx_forced, buffered_osc_out, buffered_osc_oe;
  logic divided_clock_out, divided_clock_oe, all_outputs_float_mode, lvl;
  logic ref_run = 1'b0;
  logic [1:0] rc = 2'h0;
  logic [7:0] exp_q[$];
  int fails = 0;
  int n_checks = 0;
  int seed = 81;
  int gap;
  u_xcvr_test_debug_control #(.REF_STATIC_LIMIT(REF_LIM), .DIV_RATIO(DIV)) u_xcvr_test_debug_control_i (
    .clk_sys, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .ctrl_port_enable_n, .ctrl_port_clock, .ctrl_port_serial_in, .frequency_reference_in,
    .osc_in, .framer_symbol, .tx_symbol, .tx_symbol_oe, .tx_forced, .trim_code, .buffered_osc_out,
    .buffered_osc_oe, .divided_clock_out, .divided_clock_oe, .all_outputs_float_mode);
  ctrl_port_mcu_model ctrl_port_mcu_model_i (.clk_sys, .ctrl_port_enable_n, .ctrl_port_clock, .ctrl_port_serial_in);
  always #5 clk_sys = ~clk_sys;
  // Reference comes from the bench's own counter on clk_sys, toggling every 4 cycles
  always @(posedge clk_sys)
  begin
    osc_prev <= osc_in;
    osc_in <= ~osc_in;
    framer_symbol <= 2'($random(seed));
    rc <= rc + 2'h1;
    if (ref_run && rc == 2'h0)
      frequency_reference_in <= ~frequency_reference_in;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic bus(input bit wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
    input logic [7:0] e);
    int t;
    @(posedge clk_sys);
    if (!wr)
      exp_q.push_back(e);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    t = 0;
    do
    begin
      @(posedge clk_sys);
      t++;
    end
    while (avs_waitrequest !== 1'b0 && t < 20);
    if (t >= 20)
      fails++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  always @(posedge clk_sys)
    if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0)
      check(avs_readdata[7:0], exp_q.pop_front());
  initial
  begin
    avs_address <= 4'(2'($random(seed)));
    avs_writedata <= $random(seed);
    avs_byteenable <= 4'h0;
    framer_symbol <= 2'($random(seed));
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    bus(0, OFS_FORCED_TX, 0, 0, FTX_RESET);
    bus(0, OFS_CONTROL, 0, 0, 8'(CTL_RESET));
    bus(0, OFS_TRIM, 0, 0, TRIM_CENTRE);
    bus(0, 4'h2, 0, 0, 8'h00);
    bus(1, OFS_TRIM, 32'h11, 4'hF, 0);
    bus(1, OFS_FORCED_TX, 32'h80, 4'h0, 0);
    bus(0, OFS_FORCED_TX, 0, 0, FTX_RESET);
    bus(0, OFS_TRIM, 0, 0, TRIM_CENTRE);
    bus(1, OFS_FORCED_TX, 32'h85, 4'h1, 0);
    bus(0, OFS_STATUS, 0, 0, 8'h0A);
    for (int s = 0; s < 16; s++)
    begin
      bus(1, OFS_FORCED_TX, 32'h80 | s, 4'h1, 0);
      cyc(1);
      check(tx_forced, s <= FTX_LAST_SEL);
    end
    bus(1, OFS_FORCED_TX, 0, 4'h1, 0);
    ctrl_port_mcu_model_i.qualify(32);
    ctrl_port_mcu_model_i.leave(0);
    ctrl_port_mcu_model_i.qualify(32);
    cyc(4);
    check(all_outputs_float_mode, 1'b0);
    ctrl_port_mcu_model_i.qualify(1);
    cyc(4);
    check(all_outputs_float_mode, 1'b1);
    check({tx_symbol_oe, buffered_osc_oe, divided_clock_oe}, 3'h0);
    ctrl_port_mcu_model_i.qualify(5);
    cyc(1);
    check(all_outputs_float_mode, 1'b1);
    ctrl_port_mcu_model_i.leave(1);
    cyc(3);
    check(all_outputs_float_mode, 1'b0);
    ctrl_port_mcu_model_i.qualify(33);
    cyc(4);
    check(all_outputs_float_mode, 1'b1);
    ctrl_port_mcu_model_i.leave(0);
    cyc(4);
    check(all_outputs_float_mode, 1'b0);
    ctrl_port_mcu_model_i.leave(1);
    bus(1, OFS_CONTROL, 32'h1, 4'h1, 0);
    cyc(REF_LIM + 10);
    check(trim_code, TRIM_MAX);
    bus(0, OFS_STATUS, 0, 0, 8'h08);
    ref_run = 1'b1;
    cyc(20);
    check(trim_code, TRIM_MIN);
    bus(0, OFS_STATUS, 0, 0, 8'h04);
    ref_run = 1'b0;
    cyc(REF_LIM + 10);
    check(trim_code, TRIM_MAX);
    bus(1, OFS_CONTROL, 32'h0, 4'h1, 0);
    cyc(3);
    check(trim_code, TRIM_CENTRE);
    for (int k = 0; k < 4; k++)
    begin
      cyc(1);
      check({buffered_osc_oe, buffered_osc_out}, {1'b1, osc_prev});
    end
    for (int k = 0; k < 3; k++)
    begin
      gap = 0;
      lvl = divided_clock_out;
      do
      begin
        cyc(1);
        gap++;
      end
      while (divided_clock_out === lvl && gap < 99);
      if (k > 0)
        check(gap, DIV / 2);
    end
    bus(1, OFS_CONTROL, 32'h2, 4'h1, 0);
    cyc(2);
    check({buffered_osc_oe, divided_clock_oe}, 2'b01);
    finish_test();
  end
  initial
  begin
    #200000;
    fails++;
    finish_test();
  end
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
endmodule
`default_nettype wire
